// ---- inc/ppih_pkg.sv ----
package ppih_pkg;

    // Register select codes on {reg_sel_hi, reg_sel_lo}
    localparam logic [1:0] RS_DATA_A = 2'h0;
    localparam logic [1:0] RS_CTRL_A = 2'h1;
    localparam logic [1:0] RS_DATA_B = 2'h2;
    localparam logic [1:0] RS_CTRL_B = 2'h3;

    // Control register field positions
    localparam int FLAG1_BIT = 7;
    localparam int FLAG2_BIT = 6;
    localparam int LINE_OUT_BIT = 5;
    localparam int LINE_EDGE_BIT = 4;
    localparam int LINE_EN_BIT = 3;
    localparam int DATA_SEL_BIT = 2;
    localparam int STB_EDGE_BIT = 1;
    localparam int STB_EN_BIT = 0;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] OUT_RST = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam logic LINE_IDLE = 1'b1;

    // Control line output modes, control bits 5..3
    localparam logic [2:0] MODE_HANDSHAKE = 3'h4;
    localparam logic [2:0] MODE_PULSE = 3'h5;

    typedef struct packed {
        logic take;
        logic read;
        logic [1:0] rs;
        logic [7:0] wdata;
    } ppih_req_t;

    typedef struct packed {
        logic [7:0] ctl;
        logic stb_prev;
        logic line_prev;
    } ppih_side_st_t;

    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] outr;
    } ppih_port_st_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic rvalid;
        logic line_lvl;
    } ppih_top_st_t;

endpackage

// ---- verilog/ppih_side.sv ----
`timescale 1ns/1ps
module ppih_side (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic ctl_wr_in,
    input wire logic [7:0] wdata_in,
    input wire logic flag_clr_in,
    input wire logic strobe_in,
    input wire logic line_in,
    output logic [7:0] ctl_out,
    output logic irq_out,
    output logic strobe_edge_out
);
    ppih_pkg::ppih_side_st_t q;
    ppih_pkg::ppih_side_st_t d;
    logic line_edge;

    assign strobe_edge_out = (strobe_in != q.stb_prev)
        && (strobe_in == q.ctl[ppih_pkg::STB_EDGE_BIT]);

    // Line edge only while line is an input
    assign line_edge = !q.ctl[ppih_pkg::LINE_OUT_BIT] && (line_in != q.line_prev)
        && (line_in == q.ctl[ppih_pkg::LINE_EDGE_BIT]);

    always_comb begin
        d = q;
        // Previous samples load even in reset, so no false edge at release
        d.stb_prev = strobe_in;
        d.line_prev = line_in;
        if (ctl_wr_in) begin
            d.ctl[ppih_pkg::FLAG2_BIT-1:0] = wdata_in[ppih_pkg::FLAG2_BIT-1:0];
        end
        if (flag_clr_in) begin
            d.ctl[ppih_pkg::FLAG1_BIT] = 1'b0;
            d.ctl[ppih_pkg::FLAG2_BIT] = 1'b0;
        end
        if (strobe_edge_out) begin
            d.ctl[ppih_pkg::FLAG1_BIT] = 1'b1;
        end
        if (line_edge) begin
            d.ctl[ppih_pkg::FLAG2_BIT] = 1'b1;
        end
        if (!resetn_in) begin
            d.ctl = ppih_pkg::CTRL_RST;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        q <= d;
    end

    assign ctl_out = q.ctl;

    assign irq_out = (q.ctl[ppih_pkg::FLAG1_BIT] && q.ctl[ppih_pkg::STB_EN_BIT])
        || (q.ctl[ppih_pkg::FLAG2_BIT] && q.ctl[ppih_pkg::LINE_EN_BIT]);
endmodule

// ---- verilog/ppih_port.sv ----
`timescale 1ns/1ps
module ppih_port #(
    parameter bit READ_PINS = 1'b1
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic dir_wr_in,
    input wire logic out_wr_in,
    input wire logic [7:0] wdata_in,
    input wire logic sel_dir_in,
    input wire logic [7:0] lines_in,
    output logic [7:0] lines_out,
    output logic [7:0] lines_oe_out,
    output logic [7:0] rdata_out
);
    ppih_pkg::ppih_port_st_t q;
    ppih_pkg::ppih_port_st_t d;
    logic [7:0] data_view;

    always_comb begin
        d = q;
        if (dir_wr_in) begin
            d.dir = wdata_in;
        end
        if (out_wr_in) begin
            d.outr = wdata_in;
        end
        if (!resetn_in) begin
            d.dir = ppih_pkg::DIR_RST;
            d.outr = ppih_pkg::OUT_RST;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        q <= d;
    end

    assign lines_out = q.outr;
    // Drive only where direction is 1
    assign lines_oe_out = q.dir;

    // Pins, or stored bits on output lines
    assign data_view = READ_PINS ? lines_in : ((q.dir & q.outr) | (~q.dir & lines_in));
    assign rdata_out = sel_dir_in ? q.dir : data_view;
endmodule

// ---- verilog/ppih_top.sv ----
// Contract
// - One active-low, wire-OR capable interrupt output per side, own port only.
// - Select 00 gives data A if control A bit 2, else direction A; 01 control A.
// - Control bits 7 and 6 are interrupt flags able to pull the side's request.
// - A strobe edge always sets A flag 7; bit 0 enables its interrupt.
// - A line edge sets A flag 6; bit 3 at 0 disables its interrupt.
// - A selected read of port A data clears both A flags.
// - B strobe sets B flag 7, bit 0 enables its interrupt; B line sets flag 6, bit 3 enables its.
// - A selected read of port B data clears both B flags.
// - Request low when flag 7 and bit 0, or flag 6 and bit 3, are set.
// - Port line drives when its direction bit is 1, input when 0.
// - Port B input lines have their drivers off.
// - A control bit 1 picks strobe edge: 0 falling, 1 rising.
// - With A bit 5 at 0, A line is an input setting flag 6 on bit-4 edge.
// - A bits 5,4,3 at 1,0,1 give a low pulse on A line after each A data read.
// - In handshake mode an A data read drives A line low.
// - A bits 5,4 at 1,1 make A line a static output equal to bit 3.
// - Port A data read returns the pin levels on every line.
// - Port B data read returns stored bits on outputs, pins on inputs.
// - The A line pulse lasts one clock cycle, after the read.
// - Handshake mode is 1,0,0; A strobe edge returns A line high.
`timescale 1ns/1ps
module ppih_top (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic bus_strobe_in,
    input wire logic cs0_in,
    input wire logic cs1_in,
    input wire logic cs2_n_in,
    input wire logic reg_sel_lo_in,
    input wire logic reg_sel_hi_in,
    input wire logic read_in,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_out,
    output logic side_a_irq_n_out,
    output logic side_a_irq_oe_out,
    output logic side_b_irq_n_out,
    output logic side_b_irq_oe_out,
    input wire logic a_strobe_in,
    input wire logic a_ctrl_line_in,
    output logic a_ctrl_line_out,
    output logic a_ctrl_line_oe_out,
    input wire logic b_strobe_in,
    input wire logic b_ctrl_line_in,
    input wire logic [7:0] port_a_lines_in,
    output logic [7:0] port_a_lines_out,
    output logic [7:0] port_a_lines_oe_out,
    input wire logic [7:0] port_b_lines_in,
    output logic [7:0] port_b_lines_out,
    output logic [7:0] port_b_lines_oe_out
);
    ppih_pkg::ppih_req_t req;
    ppih_pkg::ppih_top_st_t q;
    ppih_pkg::ppih_top_st_t d;
    logic [7:0] ctl_a;
    logic [7:0] ctl_b;
    logic [7:0] rd_port_a;
    logic [7:0] rd_port_b;
    logic irq_a;
    logic irq_b;
    logic a_stb_edge;
    logic b_stb_edge;
    logic acc_a;
    logic acc_b;
    logic rd_a_data;
    logic rd_b_data;
    logic wr_a_data;
    logic wr_a_dir;
    logic wr_b_data;
    logic wr_b_dir;
    logic wr_ctl_a;
    logic wr_ctl_b;
    logic [2:0] a_mode;
    logic hs_mode;
    logic pulse_mode;

    assign req.take = bus_strobe_in && cs0_in && cs1_in && !cs2_n_in;
    assign req.read = read_in;
    assign req.rs = {reg_sel_hi_in, reg_sel_lo_in};
    assign req.wdata = data_in;

    assign acc_a = req.take && (req.rs == ppih_pkg::RS_DATA_A);
    assign acc_b = req.take && (req.rs == ppih_pkg::RS_DATA_B);
    assign rd_a_data = acc_a && req.read && ctl_a[ppih_pkg::DATA_SEL_BIT];
    assign rd_b_data = acc_b && req.read && ctl_b[ppih_pkg::DATA_SEL_BIT];
    assign wr_a_data = acc_a && !req.read && ctl_a[ppih_pkg::DATA_SEL_BIT];
    assign wr_b_data = acc_b && !req.read && ctl_b[ppih_pkg::DATA_SEL_BIT];
    assign wr_a_dir = acc_a && !req.read && !ctl_a[ppih_pkg::DATA_SEL_BIT];
    assign wr_b_dir = acc_b && !req.read && !ctl_b[ppih_pkg::DATA_SEL_BIT];
    assign wr_ctl_a = req.take && !req.read && (req.rs == ppih_pkg::RS_CTRL_A);
    assign wr_ctl_b = req.take && !req.read && (req.rs == ppih_pkg::RS_CTRL_B);

    ppih_side u_side_a (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .ctl_wr_in(wr_ctl_a),
        .wdata_in(req.wdata),
        .flag_clr_in(rd_a_data),
        .strobe_in(a_strobe_in),
        .line_in(a_ctrl_line_in),
        .ctl_out(ctl_a),
        .irq_out(irq_a),
        .strobe_edge_out(a_stb_edge)
    );

    // B line output modes are not built; with B bit 5 set the line sets no flag
    ppih_side u_side_b (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .ctl_wr_in(wr_ctl_b),
        .wdata_in(req.wdata),
        .flag_clr_in(rd_b_data),
        .strobe_in(b_strobe_in),
        .line_in(b_ctrl_line_in),
        .ctl_out(ctl_b),
        .irq_out(irq_b),
        .strobe_edge_out(b_stb_edge)
    );

    ppih_port #(
        .READ_PINS(1'b1)
    ) u_port_a (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .dir_wr_in(wr_a_dir),
        .out_wr_in(wr_a_data),
        .wdata_in(req.wdata),
        .sel_dir_in(!ctl_a[ppih_pkg::DATA_SEL_BIT]),
        .lines_in(port_a_lines_in),
        .lines_out(port_a_lines_out),
        .lines_oe_out(port_a_lines_oe_out),
        .rdata_out(rd_port_a)
    );

    // Port B reads back stored bits, so loaded outputs still read correctly
    ppih_port #(
        .READ_PINS(1'b0)
    ) u_port_b (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .dir_wr_in(wr_b_dir),
        .out_wr_in(wr_b_data),
        .wdata_in(req.wdata),
        .sel_dir_in(!ctl_b[ppih_pkg::DATA_SEL_BIT]),
        .lines_in(port_b_lines_in),
        .lines_out(port_b_lines_out),
        .lines_oe_out(port_b_lines_oe_out),
        .rdata_out(rd_port_b)
    );

    assign a_mode = ctl_a[ppih_pkg::LINE_OUT_BIT:ppih_pkg::LINE_EN_BIT];
    assign hs_mode = (a_mode == ppih_pkg::MODE_HANDSHAKE);
    assign pulse_mode = (a_mode == ppih_pkg::MODE_PULSE);

    always_comb begin
        d = q;
        d.rvalid = 1'b0;
        if (req.take && req.read) begin
            d.rvalid = 1'b1;
            unique case (req.rs)
                ppih_pkg::RS_DATA_A: begin
                    d.rdata = rd_port_a;
                end
                ppih_pkg::RS_CTRL_A: begin
                    d.rdata = ctl_a;
                end
                ppih_pkg::RS_DATA_B: begin
                    d.rdata = rd_port_b;
                end
                ppih_pkg::RS_CTRL_B: begin
                    d.rdata = ctl_b;
                end
            endcase
        end
        if (hs_mode) begin
            if (rd_a_data) begin
                d.line_lvl = 1'b0;
            end
            // Strobe edge raises it, and wins a tie
            if (a_stb_edge) begin
                d.line_lvl = 1'b1;
            end
        end else if (pulse_mode) begin
            // Low for the one cycle after a read
            d.line_lvl = !rd_a_data;
        end else begin
            d.line_lvl = ppih_pkg::LINE_IDLE;
        end
        if (!resetn_in) begin
            d.rdata = ppih_pkg::RDATA_RST;
            d.rvalid = 1'b0;
            d.line_lvl = ppih_pkg::LINE_IDLE;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        q <= d;
    end

    assign data_out = q.rdata;
    assign data_oe_out = q.rvalid;

    // Manual level from bit 3, else the mode register
    assign a_ctrl_line_out = ctl_a[ppih_pkg::LINE_EDGE_BIT] ?
        ctl_a[ppih_pkg::LINE_EN_BIT] : q.line_lvl;
    assign a_ctrl_line_oe_out = ctl_a[ppih_pkg::LINE_OUT_BIT];

    // Open drain: only ever pull low
    assign side_a_irq_n_out = 1'b0;
    assign side_a_irq_oe_out = irq_a;
    assign side_b_irq_n_out = 1'b0;
    assign side_b_irq_oe_out = irq_b;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);

    // Expected port B read view, built from the pins so the check is not the design's own
    logic [7:0] b_mix;
    assign b_mix = (port_b_lines_oe_out & port_b_lines_out)
        | (~port_b_lines_oe_out & port_b_lines_in);

    sequence s_pulse_read;
        (rd_a_data && pulse_mode) ##1 (!rd_a_data && pulse_mode);
    endsequence

    sequence s_hs_read;
        rd_a_data && hs_mode && !a_stb_edge;
    endsequence

    a_irq_a_gate: assert property (
        side_a_irq_oe_out == ((ctl_a[7] && ctl_a[0]) || (ctl_a[6] && ctl_a[3]))
    ) else $error("side A request does not match flags and enables");

    a_irq_open_drain: assert property (
        !side_a_irq_n_out && !side_b_irq_n_out
    ) else $error("interrupt output drives high");

    a_flag_a_rise: assert property (
        ($rose(a_strobe_in) && ctl_a[1]) |=> ctl_a[7]
    ) else $error("rising strobe did not set A flag 7");

    a_flag_b_fall: assert property (
        ($fell(b_strobe_in) && !ctl_b[1]) |=> ctl_b[7]
    ) else $error("falling strobe did not set B flag 7");

    a_flag_a_clear: assert property (
        (rd_a_data && !a_stb_edge) |=> !ctl_a[7]
    ) else $error("A data read did not clear flag 7");

    a_flag_b_clear: assert property (
        (rd_b_data && !b_stb_edge) |=> !ctl_b[7]
    ) else $error("B data read did not clear flag 7");

    // Flag 7 is compared whichever way it stands, so a set or a cleared flag is watched
    a_write_keeps_flags: assert property (
        (wr_ctl_a && !a_stb_edge) |-> (ctl_a[7] ##1 ctl_a[7]) or (!ctl_a[7] ##1 !ctl_a[7])
    ) else $error("control write changed flags");

    a_ctl_write_lands: assert property (
        wr_ctl_a |=> (ctl_a[5:0] == $past(data_in[5:0]))
    ) else $error("control A write not stored");

    a_dir_write_drives: assert property (
        wr_a_dir |=> (port_a_lines_oe_out == $past(data_in))
    ) else $error("direction A write not applied to drivers");

    a_pulse_one_cycle: assert property (
        s_pulse_read |-> !a_ctrl_line_out ##1 (a_ctrl_line_out || !pulse_mode)
    ) else $error("A line pulse is not one cycle low");

    a_hs_read_low: assert property (
        s_hs_read |=> (!a_ctrl_line_out && a_ctrl_line_oe_out)
    ) else $error("handshake read did not drop A line");

    a_hs_release: assert property (
        (a_stb_edge && hs_mode) |=> (a_ctrl_line_out || !hs_mode)
    ) else $error("strobe edge did not raise A line");

    a_manual_level: assert property (
        (ctl_a[5] && ctl_a[4]) |-> (a_ctrl_line_oe_out && a_ctrl_line_out == ctl_a[3])
    ) else $error("manual A line level wrong");

    a_read_a_pins: assert property (
        rd_a_data |=> (data_oe_out && data_out == $past(port_a_lines_in))
    ) else $error("port A read is not the pin levels");

    a_read_b_mix: assert property (
        rd_b_data |=> (data_out == $past(b_mix))
    ) else $error("port B read mixes wrong bits");

    a_reset_clears: assert property (
        @(posedge sys_clk_in) disable iff (1'b0)
        !resetn_in |=> (ctl_a == 8'h00 && ctl_b == 8'h00 && port_a_lines_oe_out == 8'h00
            && port_b_lines_oe_out == 8'h00 && port_b_lines_out == 8'h00)
    ) else $error("reset left a register set");
endmodule

// ---- tb/ppih_periph.sv ----
`timescale 1ns/1ps
module ppih_periph (
    input wire logic clk_in,
    input wire logic [7:0] pa_out_in,
    input wire logic [7:0] pa_oe_in,
    input wire logic [7:0] pb_out_in,
    input wire logic [7:0] pb_oe_in,
    input wire logic line_out_in,
    input wire logic line_oe_in,
    output logic [7:0] pa_pin_out,
    output logic [7:0] pb_pin_out,
    output logic a_stb_out,
    output logic a_line_out,
    output logic b_stb_out,
    output logic b_line_out
);
    logic [7:0] pa_drv = 8'hff, pa_load = 8'h00, pb_drv = 8'h00, pb_load = 8'h00;
    logic a_line_drv = 1'b1, line_prev = 1'b1, hs_auto = 1'b0;
    int hs_delay = 0, hs_cnt = 0;
    // Port A pulls up; a heavy load can still hold a driven line low
    assign pa_pin_out = ((pa_oe_in & pa_out_in) | (~pa_oe_in & pa_drv)) & ~pa_load;
    assign pb_pin_out = (pb_oe_in & pb_out_in & ~pb_load) | (~pb_oe_in & pb_drv);
    assign a_line_out = line_oe_in ? line_out_in : a_line_drv;
    initial begin
        a_stb_out = 1'b0;
        b_stb_out = 1'b0;
        b_line_out = 1'b0;
    end
    task automatic set_level(input int which, input logic lvl);
        @(negedge clk_in);
        case (which)
            0: a_stb_out = lvl;
            1: a_line_drv = lvl;
            2: b_stb_out = lvl;
            default: b_line_out = lvl;
        endcase
    endtask
    always @(negedge clk_in) begin
        line_prev <= a_line_out;
        if (hs_auto && line_oe_in && line_prev && !a_line_out) begin
            hs_cnt <= hs_delay + 1;
            a_stb_out <= 1'b0;
        end else if (hs_cnt == 1) begin
            pa_drv <= pa_drv + 8'h11;
            a_stb_out <= 1'b1;
            hs_cnt <= 0;
        end else if (hs_cnt > 1) begin
            hs_cnt <= hs_cnt - 1;
        end
    end
endmodule

// ---- tb/ppih_top_test.sv ----
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
        end \
    end
module ppih_top_test;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic bus_stb = 1'b0, cs0 = 1'b0, cs1 = 1'b0, cs2_n = 1'b1, rs_hi = 1'b0, rs_lo = 1'b0;
    logic rd = 1'b1;
    logic [7:0] wdata = 8'h00;
    logic [7:0] data_out, pa_out, pa_oe, pa_pin, pb_out, pb_oe, pb_pin;
    logic data_oe, a_irq_n, a_irq_oe, b_irq_n, b_irq_oe, line_out, line_oe;
    logic a_stb, a_line, b_stb, b_line;
    int num_errors = 0;
    int n_checks = 0;
    always #2.5 sys_clk = ~sys_clk;
    ppih_top i_ppih_top (
        .sys_clk_in(sys_clk), .resetn_in(resetn), .bus_strobe_in(bus_stb),
        .cs0_in(cs0), .cs1_in(cs1), .cs2_n_in(cs2_n),
        .reg_sel_lo_in(rs_lo), .reg_sel_hi_in(rs_hi), .read_in(rd), .data_in(wdata),
        .data_out(data_out), .data_oe_out(data_oe),
        .side_a_irq_n_out(a_irq_n), .side_a_irq_oe_out(a_irq_oe),
        .side_b_irq_n_out(b_irq_n), .side_b_irq_oe_out(b_irq_oe),
        .a_strobe_in(a_stb), .a_ctrl_line_in(a_line),
        .a_ctrl_line_out(line_out), .a_ctrl_line_oe_out(line_oe),
        .b_strobe_in(b_stb), .b_ctrl_line_in(b_line),
        .port_a_lines_in(pa_pin), .port_a_lines_out(pa_out), .port_a_lines_oe_out(pa_oe),
        .port_b_lines_in(pb_pin), .port_b_lines_out(pb_out), .port_b_lines_oe_out(pb_oe)
    );
    ppih_periph i_ppih_periph (
        .clk_in(sys_clk), .pa_out_in(pa_out), .pa_oe_in(pa_oe), .pb_out_in(pb_out),
        .pb_oe_in(pb_oe), .line_out_in(line_out), .line_oe_in(line_oe),
        .pa_pin_out(pa_pin), .pb_pin_out(pb_pin), .a_stb_out(a_stb), .a_line_out(a_line),
        .b_stb_out(b_stb), .b_line_out(b_line)
    );
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // One access: request held over one taking edge, read data seen on the falling edge half a cycle after it
    task automatic bus(input logic [1:0] rs, input logic rdn, input logic [7:0] wd,
                       output logic [7:0] rv);
        @(negedge sys_clk);
        {bus_stb, cs0, cs1, cs2_n, rs_hi, rs_lo, rd, wdata} = {4'he, rs, rdn, wd};
        @(negedge sys_clk);
        {bus_stb, cs0, cs1, cs2_n, rd} = 5'h03;
        rv = data_out;
        `CHK("data_oe", rdn, data_oe)
    endtask
    task automatic wr(input logic [1:0] rs, input logic [7:0] wd);
        logic [7:0] v;
        bus(rs, 1'b0, wd, v);
    endtask
    task automatic rchk(input string nm, input logic [1:0] rs, input logic [7:0] exp);
        logic [7:0] v;
        bus(rs, 1'b1, 8'h00, v);
        `CHK(nm, exp, v)
    endtask
    initial begin
        #20000;
        num_errors++;
        finish_test();
    end
    initial begin
        logic [7:0] v, exp;
        repeat (12) @(negedge sys_clk);
        resetn = 1'b1;
        `CHK("oe_idle", 19'h0, {pa_oe, pb_oe, line_oe, a_irq_oe, b_irq_oe})
        `CHK("irq_n", 2'b00, {a_irq_n, b_irq_n})
        for (int r = 0; r < 4; r++) rchk("reset_reg", 2'(r), 8'h00);
        $display("test reset done");
        wr(ppih_pkg::RS_DATA_A, 8'h0f);
        rchk("dir_a", ppih_pkg::RS_DATA_A, 8'h0f);
        wr(ppih_pkg::RS_CTRL_A, 8'h04);
        wr(ppih_pkg::RS_DATA_A, 8'ha5);
        i_ppih_periph.pa_drv = 8'h3c;
        i_ppih_periph.pa_load = 8'h01;
        `CHK("pa_drive", 16'h0fa5, {pa_oe, pa_out})
        rchk("pins_a", ppih_pkg::RS_DATA_A, 8'h34);
        wr(ppih_pkg::RS_DATA_B, 8'hf0);
        rchk("dir_b", ppih_pkg::RS_DATA_B, 8'hf0);
        wr(ppih_pkg::RS_CTRL_B, 8'h04);
        wr(ppih_pkg::RS_DATA_B, 8'h5a);
        i_ppih_periph.pb_drv = 8'h0f;
        i_ppih_periph.pb_load = 8'hf0;
        `CHK("pb_drive", 16'hf05a, {pb_oe, pb_out})
        rchk("pins_b", ppih_pkg::RS_DATA_B, 8'h5f);
        i_ppih_periph.pa_load = 8'h00;
        i_ppih_periph.pb_load = 8'h00;
        $display("test ports done");
        // Sides, sources (strobe, line) and both edge polarities
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 4; k++) begin
                logic [1:0] crs, drs;
                logic [7:0] ctl, fl, en;
                crs = s ? ppih_pkg::RS_CTRL_B : ppih_pkg::RS_CTRL_A;
                drs = s ? ppih_pkg::RS_DATA_B : ppih_pkg::RS_DATA_A;
                fl = 8'h1 << (k[1] ? ppih_pkg::FLAG2_BIT : ppih_pkg::FLAG1_BIT);
                en = 8'h1 << (k[1] ? ppih_pkg::LINE_EN_BIT : ppih_pkg::STB_EN_BIT);
                ctl = 8'h04 | (8'(k[0]) << (k[1] ? ppih_pkg::LINE_EDGE_BIT :
                                               ppih_pkg::STB_EDGE_BIT));
                i_ppih_periph.set_level(s * 2 + k[1], k[0]);
                wr(crs, ctl);
                bus(drs, 1'b1, 8'h00, v);
                i_ppih_periph.set_level(s * 2 + k[1], !k[0]);
                repeat (3) @(negedge sys_clk);
                rchk("no_flag", crs, ctl);
                i_ppih_periph.set_level(s * 2 + k[1], k[0]);
                repeat (3) @(negedge sys_clk);
                rchk("flag_set", crs, ctl | fl);
                `CHK("irq_off", 2'b00, {a_irq_oe, b_irq_oe})
                wr(crs, ctl | en | 8'hc0);
                rchk("flag_kept", crs, ctl | en | fl);
                `CHK("irq_on", s ? 2'b01 : 2'b10, {a_irq_oe, b_irq_oe})
                bus(drs, 1'b1, 8'h00, v);
                rchk("flag_clr", crs, ctl | en);
                `CHK("irq_clr", 2'b00, {a_irq_oe, b_irq_oe})
            end
        end
        $display("test flags done");
        wr(ppih_pkg::RS_CTRL_A, 8'h2c);
        `CHK("pulse_idle", 2'b11, {line_oe, line_out})
        bus(ppih_pkg::RS_DATA_A, 1'b1, 8'h00, v);
        `CHK("pulse_low", 2'b10, {line_oe, line_out})
        @(negedge sys_clk);
        `CHK("pulse_end", 2'b11, {line_oe, line_out})
        $display("test pulse done");
        wr(ppih_pkg::RS_CTRL_A, 8'h00);
        wr(ppih_pkg::RS_DATA_A, 8'h00);
        i_ppih_periph.hs_auto = 1'b1;
        // Prompt and slow peripheral
        for (int d = 0; d < 10; d += 5) begin
            i_ppih_periph.hs_delay = d;
            wr(ppih_pkg::RS_CTRL_A, 8'h27);
            repeat (12) @(negedge sys_clk);
            exp = i_ppih_periph.pa_drv + 8'h11;
            bus(ppih_pkg::RS_DATA_A, 1'b1, 8'h00, v);
            `CHK("hs_low", 1'b0, line_out)
            for (int t = 0; t < 30 && line_out !== 1'b1; t++) @(negedge sys_clk);
            `CHK("hs_high", 1'b1, line_out)
            repeat (2) @(negedge sys_clk);
            `CHK("hs_irq", 1'b1, a_irq_oe)
            rchk("hs_data", ppih_pkg::RS_DATA_A, exp);
        end
        i_ppih_periph.hs_auto = 1'b0;
        $display("test handshake done");
        wr(ppih_pkg::RS_CTRL_A, 8'h30);
        `CHK("man_low", 2'b10, {line_oe, line_out})
        wr(ppih_pkg::RS_CTRL_A, 8'h38);
        `CHK("man_high", 2'b11, {line_oe, line_out})
        $display("test manual done");
        resetn = 1'b0;
        repeat (2) @(negedge sys_clk);
        resetn = 1'b1;
        `CHK("reset_again", 18'h0, {pa_oe, pb_oe, line_oe, a_irq_oe})
        $display("test second reset done");
        finish_test();
    end
endmodule
